/* File: rtl/flr_top.sv */
/*
 * Fault log recorder: captures a snapshot on a fault or forced save,
 * saves it to the nonvolatile partition under temperature gating,
 * and serves it as a block read over the serial bus.
 * Assumes snapshot inputs are stable and sweep_done pulses once per sweep.
 */
`timescale 1ns/1ps
module flr_top (
	input logic clk_sys,
	input logic srst,
	input logic scl_i,
	input logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input logic fault_evt,
	input logic sweep_done,
	input flr_pkg::flr_snap_type snap,
	input flr_pkg::flr_event_type event_rec,
	input logic [15:0] global_config_word,
	input logic signed [15:0] die_temp_c,
	input logic vstat_clr,
	output logic [7:0] vendor_status_byte,
	output logic log_present,
	output logic save_pending
);
	import flr_pkg::*;

	typedef struct packed {
		flr_bus_type bst;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic rd;
		logic [7:0] cmd;
		logic cmd_ok;
		logic extra;
		logic [7:0] idx;
		logic src_nvm;
		logic present;
		logic scl_d;
		logic sda_d;
		logic sda_oe;
		flr_log_type lst;
		logic [7:0] ci;
		logic ram_valid;
		logic hot;
		logic pend_save;
		logic pend_erase;
		logic [2:0] wp;
		logic [7:0] vstat;
		flr_snap_type hdr;
	} flr_state_type;

	flr_state_type st_r;
	flr_state_type st_nxt;

	logic [7:0] log_ram [0:LOG_LEN-1];
	flr_event_type ev_ring [0:EV_NUM-1];

	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic force_req;
	logic erase_req;
	logic [7:0] sel;
	logic [7:0] tx_byte;
	logic [7:0] cap_byte;
	logic [7:0] eo;
	logic [2:0] ev_k;
	logic nvm_we;
	logic [6:0] nvm_waddr;
	logic [7:0] nvm_wdata;
	logic nvm_rdy;
	logic [6:0] nvm_raddr;
	logic [7:0] nvm_rdata;
	logic nvm_valid;
	logic ring_we;
	logic [215:0] hdr_vec;

	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	// Events five and six of a stored log repeat event four
	function automatic logic [6:0] nvm_map(input logic [7:0] i);
		logic [7:0] r;
		r = i;
		if (i >= 8'(NVM_LEN))
			r = i - EV_LEN * (8'((i - 8'(NVM_LEN)) / EV_LEN) + 8'h1);
		return r[6:0];
	endfunction

	// Ring slot of event k, k zero being the most recent
	function automatic logic [2:0] ring_slot(input logic [2:0] wp, input logic [2:0] k);
		logic [3:0] s;
		s = 4'(wp) + 4'(EV_NUM) - 4'h1 - 4'(k);
		if (s >= 4'(EV_NUM))
			s = s - 4'(EV_NUM);
		return s[2:0];
	endfunction

	// ---------------------------------------------
	// Pin synchroniser and nonvolatile store
	// ---------------------------------------------
	flr_sync u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_i({scl_i, sda_i}),
		.level_o(pins_s)
	);

	flr_nvm u_nvm (
		.clk_sys(clk_sys),
		.srst(srst),
		.we(nvm_we),
		.waddr(nvm_waddr),
		.wdata(nvm_wdata),
		.rdy(nvm_rdy),
		.raddr(nvm_raddr),
		.rdata(nvm_rdata),
		.valid(nvm_valid)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];
	assign rise = scl_s & ~st_r.scl_d;
	assign fall = ~scl_s & st_r.scl_d;
	assign start = scl_s & st_r.scl_d & st_r.sda_d & ~sda_s;
	assign stop = scl_s & st_r.scl_d & ~st_r.sda_d & sda_s;

	// ---------------------------------------------
	// Header layout, byte 0 at the top
	// ---------------------------------------------
	assign hdr_vec = {
		PREFACE,
		st_r.hdr.fault_src,
		st_r.hdr.shared_clock_timestamp[7:0],
		st_r.hdr.shared_clock_timestamp[15:8],
		st_r.hdr.shared_clock_timestamp[23:16],
		st_r.hdr.shared_clock_timestamp[31:24],
		st_r.hdr.shared_clock_timestamp[39:32],
		st_r.hdr.shared_clock_timestamp[47:40],
		st_r.hdr.output_voltage_peak0,
		st_r.hdr.output_voltage_peak1,
		st_r.hdr.output_current_peak0,
		st_r.hdr.output_current_peak1,
		st_r.hdr.input_voltage_peak,
		st_r.hdr.external_temp_reading0,
		st_r.hdr.external_temp_reading1,
		st_r.hdr.die_temp_reading
	};

	// ---------------------------------------------
	// Capture byte and transmit byte
	// ---------------------------------------------
	always_comb
	begin
		eo = st_r.ci - HDR_LEN;
		ev_k = 3'(eo / EV_LEN);
		if (st_r.ci < HDR_LEN)
			cap_byte = hdr_vec[8'(HDR_LEN - 8'h1 - st_r.ci) * 8 +: 8];
		else
			cap_byte = ev_ring[ring_slot(st_r.wp, ev_k)][8'(eo % EV_LEN) * 8 +: 8];
	end

	assign sel = (st_r.bst == B_ACK) ? 8'h00 : st_r.idx + 8'h1;
	assign nvm_raddr = nvm_we ? 7'h00 : nvm_map(sel - 8'h1);

	always_comb
	begin
		tx_byte = IDLE_BYTE;
		if (st_r.cmd != CMD_READ)
			tx_byte = IDLE_BYTE;
		else if (sel == 8'h00)
			tx_byte = st_r.present ? LOG_LEN : 8'h00;
		else if (!st_r.present || sel > LOG_LEN)
			tx_byte = IDLE_BYTE;
		else if (st_r.src_nvm)
			tx_byte = nvm_rdata;
		else
			tx_byte = log_ram[sel - 8'h1];
	end

	// ---------------------------------------------
	// Nonvolatile write sequencing
	// ---------------------------------------------
	always_comb
	begin
		nvm_we = 1'b0;
		nvm_waddr = NVM_MARK_ADDR;
		nvm_wdata = NVM_BLANK;
		if (st_r.lst == L_IDLE && st_r.pend_erase && !st_r.hot)
			nvm_we = nvm_rdy;
		else if (st_r.lst == L_SAVE && !st_r.hot)
		begin
			nvm_we = nvm_rdy;
			if (st_r.ci == 8'h00)
				nvm_wdata = NVM_BLANK;
			else if (st_r.ci <= 8'(NVM_LEN))
			begin
				nvm_waddr = 7'(st_r.ci - 8'h1);
				nvm_wdata = log_ram[st_r.ci - 8'h1];
			end
			else
				nvm_wdata = NVM_MARK;
		end
	end

	// Event ring is frozen while a capture copies it
	assign ring_we = sweep_done && st_r.lst != L_COPY;

	// ---------------------------------------------
	// Next state
	// ---------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		force_req = 1'b0;
		erase_req = 1'b0;
		st_nxt.scl_d = scl_s;
		st_nxt.sda_d = sda_s;

		// Bus slave
		if (start)
		begin
			st_nxt.bst = B_ADDR;
			st_nxt.bitc = 4'h0;
			st_nxt.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			if (!st_r.rd && st_r.cmd_ok && !st_r.extra)
			begin
				force_req = (st_r.cmd == CMD_FSAVE);
				erase_req = (st_r.cmd == CMD_ERASE);
			end
			st_nxt.bst = B_IDLE;
			st_nxt.sda_oe = 1'b0;
			st_nxt.cmd_ok = 1'b0;
			st_nxt.extra = 1'b0;
		end
		else
		begin
			case (st_r.bst)
				B_ADDR, B_CMD:
				begin
					if (rise)
					begin
						st_nxt.sh = {st_r.sh[6:0], sda_s};
						st_nxt.bitc = st_r.bitc + 4'h1;
					end
					else if (fall && st_r.bitc == 4'h8)
					begin
						st_nxt.bst = B_ACK;
						st_nxt.sda_oe = 1'b1;
						if (st_r.bst == B_ADDR)
						begin
							st_nxt.rd = st_r.sh[0];
							st_nxt.src_nvm = !st_r.ram_valid;
							st_nxt.present = st_r.ram_valid | nvm_valid;
							if (st_r.sh[7:1] != DEV_ADDR)
							begin
								st_nxt.bst = B_SKIP;
								st_nxt.sda_oe = 1'b0;
							end
						end
						else if (!st_r.cmd_ok)
						begin
							st_nxt.cmd = st_r.sh;
							st_nxt.cmd_ok = 1'b1;
						end
						else
							st_nxt.extra = 1'b1;
					end
				end
				B_ACK:
				begin
					if (fall)
					begin
						st_nxt.bitc = 4'h0;
						st_nxt.sda_oe = 1'b0;
						st_nxt.bst = B_CMD;
						if (st_r.rd)
						begin
							st_nxt.bst = B_TX;
							st_nxt.idx = 8'h00;
							st_nxt.sh = {tx_byte[6:0], 1'b0};
							st_nxt.sda_oe = ~tx_byte[7];
							st_nxt.bitc = 4'h1;
						end
					end
				end
				B_TX:
				begin
					if (fall)
					begin
						if (st_r.bitc == 4'h8)
						begin
							st_nxt.sda_oe = 1'b0;
							st_nxt.bst = B_TXACK;
						end
						else
						begin
							st_nxt.sda_oe = ~st_r.sh[7];
							st_nxt.sh = {st_r.sh[6:0], 1'b0};
							st_nxt.bitc = st_r.bitc + 4'h1;
						end
					end
				end
				B_TXACK:
				begin
					if (rise && sda_s)
						st_nxt.bst = B_SKIP;
					else if (fall)
					begin
						st_nxt.bst = B_TX;
						st_nxt.idx = st_r.idx + 8'h1;
						st_nxt.sh = {tx_byte[6:0], 1'b0};
						st_nxt.sda_oe = ~tx_byte[7];
						st_nxt.bitc = 4'h1;
					end
				end
				default:
				begin
					st_nxt.sda_oe = 1'b0;
				end
			endcase
		end

		// Die temperature with hysteresis
		if (die_temp_c > TEMP_HOT_C)
			st_nxt.hot = 1'b1;
		else if (die_temp_c < TEMP_COOL_C)
			st_nxt.hot = 1'b0;

		// Vendor status: set wins over clear
		if (vstat_clr)
			st_nxt.vstat[VSTAT_FSAVE_BIT] = 1'b0;
		if (force_req && global_config_word[CFG_LOG_EN_BIT])
			st_nxt.vstat[VSTAT_FSAVE_BIT] = 1'b1;

		if (ring_we)
			st_nxt.wp = (st_r.wp == EV_NUM - 3'h1) ? 3'h0 : st_r.wp + 3'h1;

		// Log sequencer
		case (st_r.lst)
			L_IDLE:
			begin
				if (st_r.pend_erase && !st_r.hot && nvm_rdy)
					st_nxt.pend_erase = 1'b0;
				else if (st_r.pend_save && !st_r.pend_erase)
				begin
					st_nxt.lst = L_SAVE;
					st_nxt.ci = 8'h00;
				end
				else if (force_req)
					st_nxt.lst = L_WAIT;
				else if (fault_evt && global_config_word[CFG_LOG_EN_BIT] && !nvm_valid
					&& !st_r.ram_valid)
					st_nxt.lst = L_WAIT;
			end
			L_WAIT:
			begin
				if (sweep_done)
				begin
					st_nxt.hdr = snap;
					st_nxt.ci = 8'h00;
					st_nxt.ram_valid = 1'b0;
					st_nxt.lst = L_COPY;
				end
			end
			L_COPY:
			begin
				st_nxt.ci = st_r.ci + 8'h1;
				if (st_r.ci == LOG_LEN - 8'h1)
				begin
					st_nxt.ram_valid = 1'b1;
					st_nxt.pend_save = 1'b1;
					st_nxt.lst = L_IDLE;
				end
			end
			L_SAVE:
			begin
				if (nvm_we)
				begin
					st_nxt.ci = st_r.ci + 8'h1;
					if (st_r.ci == 8'(NVM_LEN) + 8'h1)
					begin
						st_nxt.pend_save = 1'b0;
						st_nxt.lst = L_IDLE;
					end
				end
			end
			default:
			begin
				st_nxt.lst = L_IDLE;
			end
		endcase

		// Erase drops the log and abandons any capture or save
		if (erase_req)
		begin
			st_nxt.lst = L_IDLE;
			st_nxt.ram_valid = 1'b0;
			st_nxt.pend_save = 1'b0;
			st_nxt.pend_erase = 1'b1;
		end
	end

	// ---------------------------------------------
	// Registers and memories
	// ---------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			st_r <= '0;
			st_r.scl_d <= 1'b1;
			st_r.sda_d <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	always_ff @(posedge clk_sys)
	begin
		if (st_r.lst == L_COPY)
			log_ram[st_r.ci] <= cap_byte;
		if (ring_we)
			ev_ring[st_r.wp] <= event_rec;
	end

	assign sda_o = 1'b0;
	assign sda_oe = st_r.sda_oe;
	assign vendor_status_byte = st_r.vstat;
	assign log_present = st_r.ram_valid | nvm_valid;
	assign save_pending = st_r.pend_save;
endmodule // flr_top

/* File: rtl/flr_pkg.sv */
/*
 * Constants, types and encodings shared by the fault log recorder.
 * Assumes a 50 MHz system clock and an I2C/PMBus host on the serial pins.
 */
//
// Operation
// - Log readable only after fault since erase
// - Log kept nonvolatile, removed only by erase
// - No log: byte count zero, no payload
// - Log present: exactly 147 payload bytes
// - RAM log holds all six events
// - EEPROM log: events five, six copy fourth
// - Fault near power-up may hold invalid pages
// - Log read is read-only block read
// - Forced save runs the fault save sequence
// - Forced save sets status bit 3 if enabled
// - Hot die: capture to RAM, hold EEPROM write
// - Held log written once die below 125C
// - Temperature hold also covers automatic faults
// - Bytes 0-3 carry preface signature
// - Bytes 5-10 carry timestamp, low byte first
// - Bytes 11-14 output voltage peaks, high first
// - Bytes 15-18 output current peaks, high first
// - Bytes 19-20 input voltage peak, high first
// - Bytes 21-22 channel 0 external temperature
// - Voltage fields hold mantissa only
// - Saved log locked against automatic overwrite
// - Finish sweep, then save header and events
package flr_pkg;

	// ---------------------------------------------
	// Clock and timing
	// ---------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int NVM_WR_NS = 1000;
	localparam int NVM_WR_CYC = (NVM_WR_NS * CLK_MHZ + 999) / 1000;

	// ---------------------------------------------
	// Bus address and command codes
	// ---------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h4f;
	localparam logic [7:0] CMD_READ = 8'hee;
	localparam logic [7:0] CMD_FSAVE = 8'hea;
	localparam logic [7:0] CMD_ERASE = 8'hec;
	localparam logic [7:0] IDLE_BYTE = 8'hff;

	// ---------------------------------------------
	// Log layout
	// ---------------------------------------------
	localparam logic [7:0] LOG_LEN = 8'h93;
	localparam logic [7:0] HDR_LEN = 8'h1b;
	localparam logic [7:0] EV_LEN = 8'h14;
	localparam logic [2:0] EV_NUM = 3'h6;
	localparam logic [6:0] NVM_LEN = 7'h6b;
	localparam logic [6:0] NVM_MARK_ADDR = 7'h6b;
	localparam logic [7:0] NVM_MARK = 8'ha5;
	localparam logic [7:0] NVM_BLANK = 8'h00;
	// Preface signature; value is arbitrary
	localparam logic [31:0] PREFACE = 32'h464c_0001;

	// ---------------------------------------------
	// Temperature thresholds and bit positions
	// ---------------------------------------------
	localparam logic signed [15:0] TEMP_HOT_C = 16'sh0082;
	localparam logic signed [15:0] TEMP_COOL_C = 16'sh007d;
	localparam int CFG_LOG_EN_BIT = 7;
	localparam int VSTAT_FSAVE_BIT = 3;

	// ---------------------------------------------
	// Types
	// ---------------------------------------------
	typedef struct packed {
		logic [7:0] fault_src;
		logic [47:0] shared_clock_timestamp;
		logic [15:0] output_voltage_peak0;
		logic [15:0] output_voltage_peak1;
		logic [15:0] output_current_peak0;
		logic [15:0] output_current_peak1;
		logic [15:0] input_voltage_peak;
		logic [15:0] external_temp_reading0;
		logic [15:0] external_temp_reading1;
		logic [15:0] die_temp_reading;
	} flr_snap_type;

	typedef logic [159:0] flr_event_type;

	typedef enum logic [2:0] {B_IDLE, B_ADDR, B_CMD, B_ACK, B_TX, B_TXACK, B_SKIP} flr_bus_type;
	typedef enum logic [1:0] {L_IDLE, L_WAIT, L_COPY, L_SAVE} flr_log_type;

endpackage

/* File: rtl/flr_sync.sv */
/*
 * Three-stage input synchroniser for the serial clock and data pins.
 * Assumes pins idle high; output changes once stages two and three agree.
 */
`timescale 1ns/1ps
module flr_sync (
	input logic clk_sys,
	input logic srst,
	input logic [1:0] pin_i,
	output logic [1:0] level_o
);
	logic [1:0] s1_r;
	logic [1:0] s2_r;
	logic [1:0] s3_r;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			s1_r <= 2'h3;
			s2_r <= 2'h3;
			s3_r <= 2'h3;
			level_o <= 2'h3;
		end
		else
		begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < 2; i++)
			begin
				if (s2_r[i] == s3_r[i])
					level_o[i] <= s3_r[i];
			end
		end
	end
endmodule // flr_sync

/* File: rtl/flr_nvm.sv */
/*
 * Nonvolatile log partition: header plus four events and a validity mark.
 * Assumes one byte write at a time; contents are not touched by reset.
 */
`timescale 1ns/1ps
module flr_nvm
	import flr_pkg::*;
(
	input logic clk_sys,
	input logic srst,
	input logic we,
	input logic [6:0] waddr,
	input logic [7:0] wdata,
	output logic rdy,
	input logic [6:0] raddr,
	output logic [7:0] rdata,
	output logic valid
);
	logic [7:0] mem [0:NVM_MARK_ADDR];
	logic [15:0] busy_r;

	// Array has no reset so a stored log outlives reset
	always_ff @(posedge clk_sys)
	begin
		if (we && rdy)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			busy_r <= 16'h0;
		else if (we && rdy)
			busy_r <= 16'(NVM_WR_CYC);
		else if (busy_r != 16'h0)
			busy_r <= busy_r - 16'h1;
	end

	assign rdy = (busy_r == 16'h0);
	assign rdata = (raddr <= NVM_MARK_ADDR) ? mem[raddr] : 8'h00;
	assign valid = (mem[NVM_MARK_ADDR] == NVM_MARK);
endmodule // flr_nvm

/* File: dv/flr_checker.sv */
/* Port checker for flr_top: bus drive, status bit, capture, saving.
   Bound to flr_top; one clock domain, synchronous reset. */
`timescale 1ns/1ps
module flr_checker
	import flr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic sweep_done,
	input wire logic [15:0] global_config_word,
	input wire logic signed [15:0] die_temp_c,
	input wire logic vstat_clr,
	input wire logic [7:0] vendor_status_byte,
	input wire logic log_present,
	input wire logic save_pending
);
	// ----------------
	// Helper counters
	// ----------------
	logic scl_r;
	int fall_age_r;
	int sweep_age_r;
	int hot_age_r;
	int cool_age_r;
	always_ff @(posedge clk_sys)
	begin
		scl_r <= scl_i;
		if (srst)
		begin
			fall_age_r <= 0;
			sweep_age_r <= 0;
			hot_age_r <= 0;
			cool_age_r <= 0;
		end
		else
		begin
			fall_age_r <= (scl_r && !scl_i) ? 0 : fall_age_r + 1;
			sweep_age_r <= sweep_done ? 0 : sweep_age_r + 1;
			hot_age_r <= (die_temp_c > TEMP_HOT_C) ? hot_age_r + 1 : 0;
			cool_age_r <= (save_pending && log_present && die_temp_c < TEMP_COOL_C) ?
				cool_age_r + 1 : 0;
		end
	end
	// ----------------
	// Assertions
	// ----------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	sequence s_copy_done;
		sweep_age_r inside {[140:160]};
	endsequence
	sequence s_stop_enabled;
		scl_i && $past(global_config_word[7]);
	endsequence
	a_drive_low: assert property (sda_o == 1'b0)
		else $error("open drain value not low");
	a_oe_after_fall: assert property ($changed(sda_oe) |-> fall_age_r inside {[1:8]})
		else $error("sda enable changed away from scl fall");
	a_status_cause: assert property ($rose(vendor_status_byte[3]) |-> s_stop_enabled)
		else $error("status bit set without enable");
	a_status_sticky: assert property (vendor_status_byte[3] && !vstat_clr |=> vendor_status_byte[3])
		else $error("status bit lost without clear");
	a_log_after_copy: assert property ($rose(log_present) |-> s_copy_done)
		else $error("log present not after sweep copy");
	a_hot_hold: assert property (hot_age_r > 4 |-> !$fell(save_pending))
		else $error("save finished while hot");
	a_cool_bound: assert property (cool_age_r < 7000)
		else $error("held save not finished when cool");
	a_reset_idle: assert property (disable iff (1'b0)
		srst |=> vendor_status_byte == 8'h00 && !sda_oe && !save_pending)
		else $error("outputs not idle after reset");
endmodule // flr_checker

bind flr_top flr_checker chk_u (
	.clk_sys(clk_sys),
	.srst(srst),
	.scl_i(scl_i),
	.sda_o(sda_o),
	.sda_oe(sda_oe),
	.sweep_done(sweep_done),
	.global_config_word(global_config_word),
	.die_temp_c(die_temp_c),
	.vstat_clr(vstat_clr),
	.vendor_status_byte(vendor_status_byte),
	.log_present(log_present),
	.save_pending(save_pending)
);

/* File: dv/flr_host.sv */
/* Serial bus host model: send byte and block read of the log.
   Assumes the bench wire-ands its sda with the device enable. */
`timescale 1ns/1ps
module flr_host
	import flr_pkg::*;
(
	output logic scl,
	output logic sda,
	input wire logic sda_in
);
	logic [7:0] rx[$];
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// ----------------
	// Bit level, scl idles high
	// ----------------
	// Low phase outlasts the device's drive latency after a fall
	task automatic bit_io(input logic b, output logic s);
		#20 sda = b;
		#100 scl = 1'b1;
		#40 s = sda_in;
		scl = 1'b0;
	endtask
	task automatic start();
		#40 sda = 1'b1;
		#80 scl = 1'b1;
		#80 sda = 1'b0;
		#80 scl = 1'b0;
	endtask
	task automatic stop();
		#40 sda = 1'b0;
		#40 scl = 1'b1;
		#80 sda = 1'b1;
		#80;
	endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	task automatic rd(output logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
	endtask
	// ----------------
	// Transactions
	// ----------------
	task automatic send_cmd(input logic [6:0] a, input logic [7:0] c, output logic ack);
		logic k;
		start();
		wr({a, 1'b0}, ack);
		wr(c, k);
		stop();
	endtask
	task automatic read_log();
		logic k;
		logic [7:0] b;
		logic [7:0] n;
		rx = {};
		start();
		wr({DEV_ADDR, 1'b0}, k);
		wr(CMD_READ, k);
		start();
		wr({DEV_ADDR, 1'b1}, k);
		rd(n);
		rx.push_back(n);
		bit_io(n == 8'h00, k);
		for (int i = 0; i < n; i++)
		begin
			rd(b);
			rx.push_back(b);
			bit_io(i == n - 1, k);
		end
		stop();
	endtask
endmodule // flr_host

/* File: dv/testbench.sv */
/* Self-checking bench for flr_top with the serial host model.
   Assumes a 50 MHz clock and a pull-up on the data line. */
`timescale 1ns/1ps
module testbench;
	import flr_pkg::*;
	logic clk_sys;
	logic srst;
	logic host_scl;
	logic host_sda;
	logic sda_i;
	logic sda_oe;
	logic fault_evt;
	logic sweep_done;
	flr_snap_type snap;
	flr_event_type event_rec;
	logic [15:0] global_config_word;
	logic signed [15:0] die_temp_c;
	logic vstat_clr;
	logic [7:0] vendor_status_byte;
	logic log_present;
	logic save_pending;
	logic ack;
	int err_total = 0;
	int num_checks = 0;
	int tb_cycles = 0;
	assign sda_i = host_sda & !sda_oe;
	flr_top dut_u (.clk_sys(clk_sys), .srst(srst), .scl_i(host_scl), .sda_i(sda_i),
		.sda_o(), .sda_oe(sda_oe), .fault_evt(fault_evt), .sweep_done(sweep_done),
		.snap(snap), .event_rec(event_rec), .global_config_word(global_config_word),
		.die_temp_c(die_temp_c), .vstat_clr(vstat_clr),
		.vendor_status_byte(vendor_status_byte), .log_present(log_present),
		.save_pending(save_pending));
	flr_host host_u (.scl(host_scl), .sda(host_sda), .sda_in(sda_i));
	// ----------------
	// Helpers
	// ----------------
	task automatic give_verdict();
		if (err_total == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk_sys);
		s = 1'b1;
		@(negedge clk_sys);
		s = 1'b0;
	endtask
	function automatic flr_event_type ev(input int k);
		for (int j = 0; j < 20; j++)
			ev[8*j+:8] = 8'(k * 37 + j);
	endfunction
	task automatic sweep(input int k);
		@(negedge clk_sys);
		event_rec = ev(k);
		sweep_done = 1'b1;
		@(negedge clk_sys);
		sweep_done = 1'b0;
	endtask
	task automatic prime(input int base);
		for (int k = base; k < base + 6; k++)
			sweep(k);
	endtask
	task automatic wait_for(ref logic s, input logic v, input int lim, input string what);
		int n;
		n = 0;
		while (s !== v && n < lim)
		begin
			@(negedge clk_sys);
			n++;
		end
		chk(what, v, s);
	endtask
	task automatic do_reset();
		@(negedge clk_sys);
		srst = 1'b1;
		cyc(8);
		srst = 1'b0;
		cyc(5);
	endtask
	task automatic chk_log(input int top, input logic eep);
		flr_event_type e;
		chk("count", LOG_LEN, host_u.rx[0]);
		chk("length", 148, host_u.rx.size());
		for (int i = 0; i < 4; i++)
			chk("preface", PREFACE[31-8*i -: 8], host_u.rx[1+i]);
		chk("source", snap.fault_src, host_u.rx[5]);
		for (int i = 0; i < 6; i++)
			chk("stamp", snap.shared_clock_timestamp[8*i+:8], host_u.rx[6+i]);
		for (int i = 0; i < 16; i++)
			chk("peaks", snap[127-8*i -: 8], host_u.rx[12+i]);
		for (int k = 0; k < 6; k++)
		begin
			e = ev(top - ((eep && k > 3) ? 3 : k));
			for (int j = 0; j < 20; j++)
				chk("event", e[8*j+:8], host_u.rx[28+20*k+j]);
		end
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_empty();
		host_u.send_cmd(DEV_ADDR, CMD_ERASE, ack);
		cyc(200);
		host_u.read_log();
		chk("empty count", 0, host_u.rx[0]);
		chk("empty length", 1, host_u.rx.size());
		chk("empty flag", 0, log_present);
	endtask
	task automatic t_force();
		prime(1);
		host_u.send_cmd(DEV_ADDR, CMD_FSAVE, ack);
		cyc(3);
		chk("save ack", 1, ack);
		chk("status set", 1, vendor_status_byte[3]);
		chk("no log yet", 0, log_present);
		sweep(7);
		wait_for(log_present, 1'b1, 400, "capture");
		chk("pending", 1, save_pending);
		host_u.read_log();
		chk_log(7, 1'b0);
		wait_for(save_pending, 1'b0, 8000, "save done");
		pulse(vstat_clr);
		cyc(1);
		chk("status clear", 0, vendor_status_byte[3]);
	endtask
	task automatic t_reset();
		do_reset();
		chk("status reset", 8'h00, vendor_status_byte);
		chk("log kept", 1, log_present);
		pulse(fault_evt);
		sweep(20);
		cyc(300);
		chk("locked", 0, save_pending);
		host_u.read_log();
		chk_log(7, 1'b1);
	endtask
	task automatic t_hot();
		host_u.send_cmd(DEV_ADDR, CMD_ERASE, ack);
		cyc(200);
		chk("erased", 0, log_present);
		die_temp_c = 16'sh0083;
		prime(30);
		pulse(fault_evt);
		sweep(36);
		wait_for(log_present, 1'b1, 400, "hot capture");
		cyc(2000);
		chk("hot hold", 1, save_pending);
		die_temp_c = 16'sh007c;
		wait_for(save_pending, 1'b0, 8000, "cool save");
		do_reset();
		host_u.read_log();
		chk_log(36, 1'b1);
	endtask
	task automatic t_refuse();
		host_u.send_cmd(DEV_ADDR ^ 7'h01, CMD_FSAVE, ack);
		cyc(3);
		chk("foreign ack", 0, ack);
		chk("foreign status", 0, vendor_status_byte[3]);
		global_config_word = 16'h0000;
		host_u.send_cmd(DEV_ADDR, CMD_FSAVE, ack);
		cyc(3);
		chk("status off", 0, vendor_status_byte[3]);
	endtask
	// ----------------
	// Clock, timeout, main
	// ----------------
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		tb_cycles++;
		if (tb_cycles == 90000)
		begin
			err_total++;
			give_verdict();
		end
	end
	initial
	begin
		srst = 1'b1;
		fault_evt = 1'b0;
		sweep_done = 1'b0;
		vstat_clr = 1'b0;
		event_rec = '0;
		die_temp_c = 16'sh0019;
		global_config_word = 16'h0080;
		snap = {8'h21, 48'ha6a5_a4a3_a2a1, 128'hb1b2_b3b4_b5b6_b7b8_b9ba_bbbc_bdbe_bfc0};
		cyc(8);
		srst = 1'b0;
		cyc(6);
		t_empty();
		t_force();
		t_reset();
		t_hot();
		t_refuse();
		give_verdict();
	end
endmodule // testbench
